//--- pin_partner.sv
`timescale 1ns/1ns
// far side: gate, count and trigger pins plus the serial port baud taps
module pin_partner (
  input wire logic clk,
  input wire logic rxTick,
  input wire logic txTick,
  input wire logic t1Tick,
  input wire logic t2Tick,
  output logic gateA,
  output logic gateB,
  output logic cnt0,
  output logic cnt1,
  output logic timer2_counter_select,
  output logic trig
);
  int rxCount; // receive baud ticks seen
  int txCount; // transmit baud ticks seen
  int t1Count; // timer 1 overflow pulses seen
  int t2Count; // timer 2 overflow pulses seen
  // pins idle high, as the synchronisers expect
  initial begin
    gateA = 1'b1;
    gateB = 1'b1;
    cnt0 = 1'b1;
    cnt1 = 1'b1;
    timer2_counter_select = 1'b1;
    trig = 1'b1;
    rxCount = 0;
    txCount = 0;
    t1Count = 0;
    t2Count = 0;
  end
  // serial port: count each baud tick and overflow pulse
  always @(posedge clk) begin
    rxCount += int'(rxTick === 1'b1);
    txCount += int'(txTick === 1'b1);
    t1Count += int'(t1Tick === 1'b1);
    t2Count += int'(t2Tick === 1'b1);
  end
  // gate level change just after an edge, pin a or pin b
  task automatic setGate(input logic v, input logic onB);
    @(posedge clk);
    #10;
    if (onB) begin
      gateB = v;
    end else begin
      gateA = v;
    end
  endtask
  // one low pulse: 0 count 2, 1 trigger, 2 count 0, else count 1
  task automatic fall(input int which);
    @(posedge clk);
    #10;
    case (which)
      0: timer2_counter_select = 1'b0;
      1: trig = 1'b0;
      2: cnt0 = 1'b0;
      default: cnt1 = 1'b0;
    endcase
    repeat (4) @(posedge clk);
    #10 trig = 1'b1;
    timer2_counter_select = 1'b1;
    cnt0 = 1'b1;
    cnt1 = 1'b1;
    repeat (4) @(posedge clk);
  endtask
endmodule

//--- pin_sync_edge.sv
`timescale 1ns/1ns
// two-flop synchroniser for one pin plus a falling-edge pulse
module pin_sync_edge #(
  parameter logic IDLE_LEVEL = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pinIn,
  output logic pinLevel,
  output logic pinFall
);
  logic meta_r; // first stage, read only by the second
  logic sync_r; // second stage
  logic last_r; // previous synchronised level

  // synchroniser chain and edge history
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= IDLE_LEVEL;
      sync_r <= IDLE_LEVEL;
      last_r <= IDLE_LEVEL;
    end else begin
      meta_r <= pinIn;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  assign pinLevel = sync_r;
  assign pinFall = last_r & ~sync_r;
endmodule

//--- timer_counter_set.sv
`timescale 1ns/1ns
`include "timer_set_defines.svh"
// What this block does
// - mode 0 counts high byte plus low five
// - wrap to zero sets overflow flag
// - count only when run and gate allow, except timer 1 ignores its run bit while timer 0 is split
// - starting a timer keeps its count
// - timer mode ticks every core clock
// - mode 1 is full sixteen bit count
// - mode 2 low byte reloads from high
// - timer 1 in mode 3 holds
// - timer 0 mode 3 low byte own controls
// - timer 0 high byte uses timer 1 controls
// - timer 1 runs outside mode 3, no flag
// - timer 2 flag set unless baud mode
// - trigger edge with enable sets external flag
// - receive clock from timer 2 or 1
// - transmit clock from timer 2 or 1
// - trigger edges act only when enabled
// - timer 2 counts only while run set
// - timer 2 counts pin edges or clocks
// - capture select picks capture or reload
// - baud mode forces reload on overflow
// - vectoring clears timer 0 and 1 flags
// - timer 2 rollover reloads sixteen bits
// - capture copies count into reload pair
module timer_counter_set (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrWrEn,
  input wire logic sfrRdEn,
  output logic [7:0] sfrRdData,
  input wire logic externalGateInputA,
  input wire logic externalGateInputB,
  input wire logic timer0CountPin,
  input wire logic timer1CountPin,
  input wire logic timer2CountPin,
  input wire logic timer2TriggerPin,
  input wire logic timer0VectorAck,
  input wire logic timer1VectorAck,
  output logic timer0OverflowFlag,
  output logic timer1OverflowFlag,
  output logic timer2OverflowFlag,
  output logic timer2ExternalFlag,
  output logic timer1OverflowPulse,
  output logic timer2OverflowPulse,
  output logic serialRxClkPulse,
  output logic serialTxClkPulse
);
  import timer_set_pkg::*;

  logic [7:0] runCtl_r; // timer_run_control_reg
  logic [7:0] modeReg_r; // timer_mode_reg
  logic [7:0] t0Low_r; // timer0_low_byte
  logic [7:0] t0High_r; // timer0_high_byte
  logic [7:0] t1Low_r; // timer 1 low byte
  logic [7:0] t1High_r; // timer 1 high byte
  logic [7:0] t2Ctl_r; // timer2_control
  logic [7:0] t2RelLow_r; // timer2_reload_low
  logic [7:0] t2RelHigh_r; // timer2_reload_high
  logic [7:0] t2Low_r; // timer2_low_byte
  logic [7:0] t2High_r; // timer2_high_byte
  logic t1Pulse_r; // registered timer 1 overflow
  logic t2Pulse_r; // registered timer 2 overflow

  // synchronised pins
  logic gateALevel, gateBLevel;
  logic t0Fall, t1Fall, t2Fall, trigFall;

  // fields
  timer_mode_t t0Mode, t1Mode;
  logic gate0, gate1, ct0, ct1;
  logic run0, run1;
  logic t0Split;
  logic baudMode;

  // tick enables and next values
  logic t0Tick, t0HighTick, t1Tick, t2Tick;
  logic [16:0] t0Step, t1Step;
  logic [8:0] t0HighSum;
  logic [16:0] t2Sum;
  logic t0Ovf, t0HighOvf, t1Ovf, t2Ovf;
  logic trigEvent, trigCapture, trigReload;

  // register write strobes
  logic wrRunCtl, wrMode, wrT0Low, wrT0High, wrT1Low, wrT1High;
  logic wrT2Ctl, wrT2RelLow, wrT2RelHigh, wrT2Low, wrT2High;

  // pin synchronisers, idle high so reset shows no edge
  pin_sync_edge #(.IDLE_LEVEL(1'b1)) syncGateA (
    .clk(clk), .rst_n(rst_n), .pinIn(externalGateInputA),
    .pinLevel(gateALevel), .pinFall()
  );
  pin_sync_edge #(.IDLE_LEVEL(1'b1)) syncGateB (
    .clk(clk), .rst_n(rst_n), .pinIn(externalGateInputB),
    .pinLevel(gateBLevel), .pinFall()
  );
  pin_sync_edge #(.IDLE_LEVEL(1'b1)) syncCount0 (
    .clk(clk), .rst_n(rst_n), .pinIn(timer0CountPin),
    .pinLevel(), .pinFall(t0Fall)
  );
  pin_sync_edge #(.IDLE_LEVEL(1'b1)) syncCount1 (
    .clk(clk), .rst_n(rst_n), .pinIn(timer1CountPin),
    .pinLevel(), .pinFall(t1Fall)
  );
  pin_sync_edge #(.IDLE_LEVEL(1'b1)) syncCount2 (
    .clk(clk), .rst_n(rst_n), .pinIn(timer2CountPin),
    .pinLevel(), .pinFall(t2Fall)
  );
  pin_sync_edge #(.IDLE_LEVEL(1'b1)) syncTrigger (
    .clk(clk), .rst_n(rst_n), .pinIn(timer2TriggerPin),
    .pinLevel(), .pinFall(trigFall)
  );

  // one increment of a timer 0/1 pair, returns {overflow, high, low}
  function automatic logic [16:0] stepCount(
    input timer_mode_t m,
    input logic [7:0] hi,
    input logic [7:0] lo
  );
    logic [13:0] s13;
    logic [16:0] s16;
    logic [8:0] s8;
    logic [16:0] r;
    s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
    s16 = {1'b0, hi, lo} + 17'h00001;
    s8 = {1'b0, lo} + 9'h001;
    case (m)
      // upper three low bits are left alone
      MODE_13BIT: r = {s13[13], s13[12:5], lo[7:5], s13[4:0]};
      MODE_16BIT: r = s16;
      // low byte reloads from the unchanged high byte
      MODE_RELOAD8: r = {s8[8], hi, s8[8] ? hi : s8[7:0]};
      // split: the low byte alone counts here
      MODE_SPLIT: r = {s8[8], hi, s8[7:0]};
      default: r = {1'b0, hi, lo};
    endcase
    return r;
  endfunction

  // field decode
  always_comb begin
    t0Mode = timer_mode_t'(modeReg_r[`MODE_T0_BASE +: 2]);
    t1Mode = timer_mode_t'(modeReg_r[`MODE_T1_BASE +: 2]);
    gate0 = modeReg_r[`MODE_T0_BASE + `MODE_GATE_OFS];
    gate1 = modeReg_r[`MODE_T1_BASE + `MODE_GATE_OFS];
    ct0 = modeReg_r[`MODE_T0_BASE + `MODE_CT_OFS];
    ct1 = modeReg_r[`MODE_T1_BASE + `MODE_CT_OFS];
    run0 = runCtl_r[`RC_T0_RUN];
    run1 = runCtl_r[`RC_T1_RUN];
    t0Split = (t0Mode == MODE_SPLIT);
    baudMode = t2Ctl_r[`T2_RX_CLK_SEL] | t2Ctl_r[`T2_TX_CLK_SEL];
  end

  // tick enables: run bit and gate, then clock or pin edge
  always_comb begin
    // gated input with no prescaler ahead of it
    t0Tick = run0 & (~gate0 | gateALevel) & (ct0 ? t0Fall : 1'b1);
    // high byte of a split timer 0 counts clocks on timer 1's run bit
    t0HighTick = t0Split & run1;
    if (t1Mode == MODE_SPLIT) begin
      t1Tick = 1'b0;
    end else if (t0Split) begin
      // run bit lent away: mode switch turns timer 1 on and off
      t1Tick = (~gate1 | gateBLevel) & (ct1 ? t1Fall : 1'b1);
    end else begin
      t1Tick = run1 & (~gate1 | gateBLevel) & (ct1 ? t1Fall : 1'b1);
    end
    t2Tick = t2Ctl_r[`T2_RUN] & (t2Ctl_r[`T2_CNT_SEL] ? t2Fall : 1'b1);
  end

  // next counts and overflow events
  always_comb begin
    t0Step = stepCount(t0Mode, t0High_r, t0Low_r);
    t1Step = stepCount(t1Mode, t1High_r, t1Low_r);
    t0HighSum = {1'b0, t0High_r} + 9'h001;
    t2Sum = {1'b0, t2High_r, t2Low_r} + 17'h00001;
    t0Ovf = t0Tick & t0Step[16];
    t0HighOvf = t0HighTick & t0HighSum[8];
    t1Ovf = t1Tick & t1Step[16];
    t2Ovf = t2Tick & t2Sum[16];
    trigEvent = trigFall & t2Ctl_r[`T2_EXT_EN];
    // serial clocking blocks captures and pin reloads
    trigCapture = trigEvent & ~baudMode & t2Ctl_r[`T2_CAP_SEL];
    trigReload = trigEvent & ~baudMode & ~t2Ctl_r[`T2_CAP_SEL];
  end

  // address decode
  always_comb begin
    wrRunCtl = sfrWrEn & (sfrAddr == `ADDR_RUN_CONTROL);
    wrMode = sfrWrEn & (sfrAddr == `ADDR_TIMER_MODE);
    wrT0Low = sfrWrEn & (sfrAddr == `ADDR_T0_LOW);
    wrT0High = sfrWrEn & (sfrAddr == `ADDR_T0_HIGH);
    wrT1Low = sfrWrEn & (sfrAddr == `ADDR_T1_LOW);
    wrT1High = sfrWrEn & (sfrAddr == `ADDR_T1_HIGH);
    wrT2Ctl = sfrWrEn & (sfrAddr == `ADDR_T2_CONTROL);
    wrT2RelLow = sfrWrEn & (sfrAddr == `ADDR_T2_RELOAD_LOW);
    wrT2RelHigh = sfrWrEn & (sfrAddr == `ADDR_T2_RELOAD_HIGH);
    wrT2Low = sfrWrEn & (sfrAddr == `ADDR_T2_LOW);
    wrT2High = sfrWrEn & (sfrAddr == `ADDR_T2_HIGH);
  end

  // mode register, software only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      modeReg_r <= `RESET_BYTE;
    end else if (wrMode) begin
      modeReg_r <= sfrWrData;
    end
  end

  // run control: run bits and pin bits from software, flags from hardware
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      runCtl_r <= `RESET_BYTE;
    end else begin
      if (wrRunCtl) begin
        // writing a run bit touches no count register
        runCtl_r <= sfrWrData;
      end
      // timer 0 flag: a hardware set beats write and vector clear
      if (t0Ovf) begin
        runCtl_r[`RC_T0_FLAG] <= 1'b1;
      end else if (wrRunCtl) begin
        runCtl_r[`RC_T0_FLAG] <= sfrWrData[`RC_T0_FLAG];
      end else if (timer0VectorAck) begin
        runCtl_r[`RC_T0_FLAG] <= 1'b0;
      end
      // timer 1 flag belongs to the split high byte while timer 0 is split
      if (t0Split ? t0HighOvf : t1Ovf) begin
        runCtl_r[`RC_T1_FLAG] <= 1'b1;
      end else if (wrRunCtl) begin
        runCtl_r[`RC_T1_FLAG] <= sfrWrData[`RC_T1_FLAG];
      end else if (timer1VectorAck) begin
        runCtl_r[`RC_T1_FLAG] <= 1'b0;
      end
    end
  end

  // timer 0 count, software write wins over a tick
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      t0Low_r <= `RESET_BYTE;
      t0High_r <= `RESET_BYTE;
    end else begin
      if (wrT0Low) begin
        t0Low_r <= sfrWrData;
      end else if (t0Tick) begin
        t0Low_r <= t0Step[7:0];
      end
      if (wrT0High) begin
        t0High_r <= sfrWrData;
      end else if (t0Split) begin
        if (t0HighTick) begin
          t0High_r <= t0HighSum[7:0];
        end
      end else if (t0Tick) begin
        t0High_r <= t0Step[15:8];
      end
    end
  end

  // timer 1 count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      t1Low_r <= `RESET_BYTE;
      t1High_r <= `RESET_BYTE;
    end else begin
      if (wrT1Low) begin
        t1Low_r <= sfrWrData;
      end else if (t1Tick) begin
        t1Low_r <= t1Step[7:0];
      end
      if (wrT1High) begin
        t1High_r <= sfrWrData;
      end else if (t1Tick) begin
        t1High_r <= t1Step[15:8];
      end
    end
  end

  // timer 2 control: configuration from software, flags from hardware
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      t2Ctl_r <= `RESET_BYTE;
    end else begin
      if (wrT2Ctl) begin
        t2Ctl_r <= sfrWrData;
      end
      // no overflow flag while timer 2 clocks the serial port
      if (t2Ovf & ~baudMode) begin
        t2Ctl_r[`T2_OVF_FLAG] <= 1'b1;
      end
      // external flag on an accepted trigger edge
      if (trigEvent) begin
        t2Ctl_r[`T2_EXT_FLAG] <= 1'b1;
      end
    end
  end

  // timer 2 count with reload on overflow or trigger
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      t2Low_r <= `RESET_BYTE;
      t2High_r <= `RESET_BYTE;
    end else begin
      if (wrT2Low) begin
        t2Low_r <= sfrWrData;
      end else if (trigReload | (t2Ovf & (baudMode | ~t2Ctl_r[`T2_CAP_SEL]))) begin
        t2Low_r <= t2RelLow_r;
      end else if (t2Tick) begin
        t2Low_r <= t2Sum[7:0];
      end
      if (wrT2High) begin
        t2High_r <= sfrWrData;
      end else if (trigReload | (t2Ovf & (baudMode | ~t2Ctl_r[`T2_CAP_SEL]))) begin
        t2High_r <= t2RelHigh_r;
      end else if (t2Tick) begin
        t2High_r <= t2Sum[15:8];
      end
    end
  end

  // capture/reload pair: software preset or hardware capture
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      t2RelLow_r <= `RESET_BYTE;
      t2RelHigh_r <= `RESET_BYTE;
    end else begin
      if (trigCapture) begin
        t2RelLow_r <= t2Low_r;
      end else if (wrT2RelLow) begin
        t2RelLow_r <= sfrWrData;
      end
      if (trigCapture) begin
        t2RelHigh_r <= t2High_r;
      end else if (wrT2RelHigh) begin
        t2RelHigh_r <= sfrWrData;
      end
    end
  end

  // overflow pulses for baud generation, regardless of flags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      t1Pulse_r <= 1'b0;
      t2Pulse_r <= 1'b0;
      serialRxClkPulse <= 1'b0;
      serialTxClkPulse <= 1'b0;
    end else begin
      t1Pulse_r <= t1Ovf;
      t2Pulse_r <= t2Ovf;
      serialRxClkPulse <= t2Ctl_r[`T2_RX_CLK_SEL] ? t2Ovf : t1Ovf;
      serialTxClkPulse <= t2Ctl_r[`T2_TX_CLK_SEL] ? t2Ovf : t1Ovf;
    end
  end

  // read data, one cycle after the read strobe; unmapped reads zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sfrRdData <= `RESET_BYTE;
    end else if (sfrRdEn) begin
      case (sfrAddr)
        `ADDR_RUN_CONTROL: sfrRdData <= runCtl_r;
        `ADDR_TIMER_MODE: sfrRdData <= modeReg_r;
        `ADDR_T0_LOW: sfrRdData <= t0Low_r;
        `ADDR_T0_HIGH: sfrRdData <= t0High_r;
        `ADDR_T1_LOW: sfrRdData <= t1Low_r;
        `ADDR_T1_HIGH: sfrRdData <= t1High_r;
        `ADDR_T2_CONTROL: sfrRdData <= t2Ctl_r;
        `ADDR_T2_RELOAD_LOW: sfrRdData <= t2RelLow_r;
        `ADDR_T2_RELOAD_HIGH: sfrRdData <= t2RelHigh_r;
        `ADDR_T2_LOW: sfrRdData <= t2Low_r;
        `ADDR_T2_HIGH: sfrRdData <= t2High_r;
        default: sfrRdData <= `RESET_BYTE;
      endcase
    end
  end

  // flag and pulse outputs straight from registers
  assign timer0OverflowFlag = runCtl_r[`RC_T0_FLAG];
  assign timer1OverflowFlag = runCtl_r[`RC_T1_FLAG];
  assign timer2OverflowFlag = t2Ctl_r[`T2_OVF_FLAG];
  assign timer2ExternalFlag = t2Ctl_r[`T2_EXT_FLAG];
  assign timer1OverflowPulse = t1Pulse_r;
  assign timer2OverflowPulse = t2Pulse_r;
endmodule

//--- timer_counter_set_props.sv
`timescale 1ns/1ns
`include "timer_set_defines.svh"
// watches bus reads, timer 2 flags and the baud pulses of the timer set
module timer_counter_set_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrWrEn,
  input wire logic sfrRdEn,
  input wire logic [7:0] sfrRdData,
  input wire logic timer0VectorAck,
  input wire logic timer0OverflowFlag,
  input wire logic timer2OverflowFlag,
  input wire logic timer2ExternalFlag,
  input wire logic timer1OverflowPulse,
  input wire logic timer2OverflowPulse,
  input wire logic serialRxClkPulse,
  input wire logic serialTxClkPulse
);
  logic wrT2; // write to timer 2 control
  logic clr0; // software or vector clear of timer 0 flag
  logic [1:0] t2Flags; // both timer 2 flags
  logic rxSel_r; // shadow of receive clock select
  logic txSel_r; // shadow of transmit clock select
  logic extEn_r; // shadow of external enable
  assign wrT2 = sfrWrEn && sfrAddr == `ADDR_T2_CONTROL;
  assign clr0 = timer0VectorAck || (sfrWrEn && sfrAddr == `ADDR_RUN_CONTROL);
  assign t2Flags = {timer2OverflowFlag, timer2ExternalFlag};
  // shadow the software-only control bits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxSel_r <= 1'b0;
      txSel_r <= 1'b0;
      extEn_r <= 1'b0;
    end else if (wrT2) begin
      rxSel_r <= sfrWrData[`T2_RX_CLK_SEL];
      txSel_r <= sfrWrData[`T2_TX_CLK_SEL];
      extEn_r <= sfrWrData[`T2_EXT_EN];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // overflow pulse trails the flag by at most one cycle
  sequence t2PulseSoon;
    ##[0:1] timer2OverflowPulse;
  endsequence
  AST_RX_SEL:
    assert property ($stable(rxSel_r) |-> serialRxClkPulse ==
      (rxSel_r ? timer2OverflowPulse : timer1OverflowPulse))
    else $error("receive baud pulse from wrong timer");
  AST_TX_SEL:
    assert property ($stable(txSel_r) |-> serialTxClkPulse ==
      (txSel_r ? timer2OverflowPulse : timer1OverflowPulse))
    else $error("transmit baud pulse from wrong timer");
  AST_BAUD_NOFLAG:
    assert property ((rxSel_r || txSel_r) && !$past(wrT2) |-> !$rose(timer2OverflowFlag))
    else $error("timer 2 flag set in baud mode");
  AST_T2_FLAG_HOLD:
    assert property ($past(timer2OverflowFlag) && !$past(wrT2) |-> timer2OverflowFlag)
    else $error("timer 2 flag cleared without software");
  AST_EXT_CAUSE:
    assert property ($rose(timer2ExternalFlag) && !$past(wrT2) |-> extEn_r)
    else $error("external flag set while disabled");
  AST_T0_CLEAR:
    assert property ($fell(timer0OverflowFlag) |-> $past(clr0))
    else $error("timer 0 flag cleared without cause");
  AST_T2_PULSE:
    assert property ($rose(timer2OverflowFlag) && !$past(wrT2) |-> t2PulseSoon)
    else $error("no timer 2 overflow pulse");
  AST_RD_T2FLAGS:
    assert property (sfrRdEn && sfrAddr == `ADDR_T2_CONTROL |=>
      sfrRdData[7:6] == $past(t2Flags))
    else $error("timer 2 flags read wrong");
endmodule
bind timer_counter_set timer_counter_set_props chk (
  .clk, .rst_n, .sfrAddr, .sfrWrData, .sfrWrEn, .sfrRdEn, .sfrRdData,
  .timer0VectorAck, .timer0OverflowFlag, .timer2OverflowFlag,
  .timer2ExternalFlag, .timer1OverflowPulse, .timer2OverflowPulse,
  .serialRxClkPulse, .serialTxClkPulse
);

//--- timer_counter_set_test.sv
`timescale 1ns/1ns
// self-checking bench for the three timer/counters
module timer_counter_set_test;
  logic clk, rst_n, sfrWrEn, sfrRdEn, ack0, ack1; // bus strobes and acks
  logic [7:0] sfrAddr, sfrWrData, sfrRdData; // register bus
  logic gateA, gateB, timer2_counter_select, trig, rxP, txP, f0, f1, f2; // pins and flags
  logic cnt0, cnt1, extF, p1, p2; // count pins, external flag, overflow pulses
  logic [2:0] seen; // flags caught while running
  int err_count;
  int total_checks;
  timer_counter_set dut (.clk, .rst_n, .sfrAddr, .sfrWrData, .sfrWrEn, .sfrRdEn,
    .sfrRdData, .externalGateInputA(gateA), .externalGateInputB(gateB),
    .timer0CountPin(cnt0), .timer1CountPin(cnt1), .timer2CountPin(timer2_counter_select),
    .timer2TriggerPin(trig), .timer0VectorAck(ack0), .timer1VectorAck(ack1),
    .timer0OverflowFlag(f0), .timer1OverflowFlag(f1), .timer2OverflowFlag(f2),
    .timer2ExternalFlag(extF), .timer1OverflowPulse(p1), .timer2OverflowPulse(p2),
    .serialRxClkPulse(rxP), .serialTxClkPulse(txP));
  pin_partner pins (.clk, .rxTick(rxP), .txTick(txP), .t1Tick(p1), .t2Tick(p2),
    .gateA, .gateB, .cnt0, .cnt1, .timer2_counter_select, .trig);
  // core clock, 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // byte compare
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one register write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #10 sfrAddr = a;
    sfrWrData = d;
    sfrWrEn = 1'b1;
    @(posedge clk);
    #10 sfrWrEn = 1'b0;
  endtask
  // one register read, checked
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    #10 sfrAddr = a;
    sfrRdEn = 1'b1;
    @(posedge clk);
    #10 sfrRdEn = 1'b0;
    cmp8(sfrRdData, exp);
  endtask
  // run for exactly five ticks, catching the flags before the stop
  task automatic runFor(input logic [7:0] a, input logic [7:0] on);
    wr(a, on);
    repeat (3) @(posedge clk);
    #10 seen = {f2, f1, f0};
    wr(a, 8'h00);
  endtask
  // reset values, an unmapped place, vector clears
  task automatic testReset();
    logic [7:0] ad [12] = '{8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D,
      8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'h00};
    foreach (ad[i]) rd(ad[i], 8'h00);
    wr(8'h88, 8'hA0);
    @(posedge clk);
    #10 ack0 = 1'b1;
    ack1 = 1'b1;
    @(posedge clk);
    #10 ack0 = 1'b0;
    ack1 = 1'b0;
    rd(8'h88, 8'h00);
    $display("reset test done");
  endtask
  // 16-bit wrap, 13-bit wrap with baud taps, 8-bit reload, gate
  task automatic testModes();
    int rx0, tx0;
    wr(8'h89, 8'h01);
    wr(8'h8A, 8'hFE);
    wr(8'h8C, 8'hFF);
    runFor(8'h88, 8'h10);
    cmp8({5'h0, seen}, 8'h01);
    rd(8'h8A, 8'h03);
    rd(8'h8C, 8'h00);
    wr(8'h89, 8'h00);
    wr(8'h8B, 8'hFE);
    wr(8'h8D, 8'hFF);
    rx0 = pins.rxCount;
    tx0 = pins.txCount;
    runFor(8'h88, 8'h40);
    cmp8({5'h0, seen}, 8'h02);
    rd(8'h8B, 8'hE3);
    rd(8'h8D, 8'h00);
    cmp8(8'(pins.rxCount - rx0), 8'h01);
    cmp8(8'(pins.txCount - tx0), 8'h01);
    cmp8(8'(pins.t1Count), 8'h01);
    wr(8'h89, 8'h02);
    wr(8'h8C, 8'hF0);
    wr(8'h8A, 8'hFE);
    runFor(8'h88, 8'h10);
    cmp8({5'h0, seen}, 8'h01);
    rd(8'h8A, 8'hF3);
    rd(8'h8C, 8'hF0);
    wr(8'h89, 8'h09);
    pins.setGate(1'b0, 1'b0);
    repeat (4) @(posedge clk);
    runFor(8'h88, 8'h10);
    rd(8'h8A, 8'hF3);
    pins.setGate(1'b1, 1'b0);
    $display("mode test done");
  endtask
  // timer 0 split into two bytes, timer 1 held or freed
  task automatic testSplit();
    wr(8'h89, 8'h33);
    wr(8'h8C, 8'hFE);
    wr(8'h8B, 8'h10);
    runFor(8'h88, 8'h40);
    cmp8({5'h0, seen}, 8'h02);
    rd(8'h8C, 8'h03);
    rd(8'h8B, 8'h10);
    rd(8'h8A, 8'hF3);
    wr(8'h89, 8'h03);
    wr(8'h89, 8'h33);
    rd(8'h8B, 8'h12);
    $display("split test done");
  endtask
  // timer 2 reload, baud, trigger, capture, pin counting
  task automatic testTimer2();
    int rx0, tx0;
    wr(8'hCA, 8'h34);
    wr(8'hCB, 8'h12);
    wr(8'hCC, 8'hFE);
    wr(8'hCD, 8'hFF);
    runFor(8'hC8, 8'h04);
    cmp8({5'h0, seen}, 8'h04);
    rd(8'hCC, 8'h37);
    rd(8'hCD, 8'h12);
    wr(8'hCC, 8'hFE);
    wr(8'hCD, 8'hFF);
    rx0 = pins.rxCount;
    tx0 = pins.txCount;
    runFor(8'hC8, 8'h35);
    cmp8({5'h0, seen}, 8'h00);
    rd(8'hCC, 8'h37);
    cmp8(8'(pins.rxCount - rx0), 8'h01);
    cmp8(8'(pins.txCount - tx0), 8'h01);
    cmp8(8'(pins.t2Count), 8'h02);
    wr(8'hC8, 8'h01);
    pins.fall(1'b1);
    rd(8'hC8, 8'h01);
    cmp8({7'h00, extF}, 8'h00);
    wr(8'hCC, 8'h78);
    wr(8'hCD, 8'h56);
    wr(8'hC8, 8'h09);
    pins.fall(1'b1);
    rd(8'hC8, 8'h49);
    cmp8({7'h00, extF}, 8'h01);
    rd(8'hCA, 8'h78);
    rd(8'hCB, 8'h56);
    wr(8'hCC, 8'h00);
    wr(8'hC8, 8'h06);
    pins.fall(1'b0);
    pins.fall(1'b0);
    wr(8'hC8, 8'h00);
    rd(8'hCC, 8'h02);
    $display("timer 2 test done");
  endtask
  // counter mode on the count pins, timer 1 gate pin allowing then blocking
  task automatic testCount();
    wr(8'h89, 8'hD5);
    wr(8'h8A, 8'hFE);
    wr(8'h8C, 8'hFF);
    wr(8'h8B, 8'h12);
    wr(8'h8D, 8'h00);
    wr(8'h88, 8'h50);
    pins.fall(2);
    pins.fall(2);
    pins.fall(3);
    pins.fall(0);
    rd(8'h88, 8'h70);
    wr(8'h88, 8'h00);
    rd(8'h8A, 8'h00);
    rd(8'h8C, 8'h00);
    rd(8'h8B, 8'h13);
    pins.setGate(1'b0, 1'b1);
    wr(8'h88, 8'h40);
    pins.fall(3);
    wr(8'h88, 8'h00);
    rd(8'h8B, 8'h13);
    pins.setGate(1'b1, 1'b1);
    $display("counter test done");
  endtask
  // verdict and end of run
  task automatic results();
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    err_count = 0;
    total_checks = 0;
    rst_n = 1'b0;
    sfrAddr = 8'h00;
    sfrWrData = 8'h00;
    sfrWrEn = 1'b0;
    sfrRdEn = 1'b0;
    ack0 = 1'b0;
    ack1 = 1'b0;
    repeat (3) @(posedge clk);
    #10 rst_n = 1'b1;
    testReset();
    testModes();
    testSplit();
    testTimer2();
    testCount();
    results();
  end
  // watchdog, far beyond the expected run length
  initial begin
    #2000000;
    err_count++;
    results();
  end
endmodule

//--- timer_set_defines.svh
`ifndef TIMER_SET_DEFINES_SVH
`define TIMER_SET_DEFINES_SVH

// special function register addresses
`define ADDR_RUN_CONTROL 8'h88
`define ADDR_TIMER_MODE 8'h89
`define ADDR_T0_LOW 8'h8A
`define ADDR_T1_LOW 8'h8B
`define ADDR_T0_HIGH 8'h8C
`define ADDR_T1_HIGH 8'h8D
`define ADDR_T2_CONTROL 8'hC8
`define ADDR_T2_RELOAD_LOW 8'hCA
`define ADDR_T2_RELOAD_HIGH 8'hCB
`define ADDR_T2_LOW 8'hCC
`define ADDR_T2_HIGH 8'hCD

// reset values
`define RESET_BYTE 8'h00

// run control register fields
`define RC_T1_FLAG 7
`define RC_T1_RUN 6
`define RC_T0_FLAG 5
`define RC_T0_RUN 4

// mode register fields, timer 0 in the low nibble, timer 1 in the high
`define MODE_T1_BASE 4
`define MODE_T0_BASE 0
`define MODE_GATE_OFS 3
`define MODE_CT_OFS 2

// timer 2 control fields
`define T2_OVF_FLAG 7
`define T2_EXT_FLAG 6
`define T2_RX_CLK_SEL 5
`define T2_TX_CLK_SEL 4
`define T2_EXT_EN 3
`define T2_RUN 2
`define T2_CNT_SEL 1
`define T2_CAP_SEL 0

`endif

//--- timer_set_pkg.sv
package timer_set_pkg;

  // operating modes of timers 0 and 1
  typedef enum logic [1:0] {
    MODE_13BIT = 2'b00,
    MODE_16BIT = 2'b01,
    MODE_RELOAD8 = 2'b10,
    MODE_SPLIT = 2'b11
  } timer_mode_t;

endpackage
